// ===== common/pgs_pkg.sv
// constants and types shared by the power gpio sequencer
package pgs_pkg;
  localparam int CLOCK_HZ = 20000000;
  // longest allowed gap between paired pin edges, in nanoseconds (12.5 us)
  localparam int PIN_GAP_NS = 12500;
  // longest time rounds down, at least one cycle
  localparam int PIN_GAP_CYCLES_RAW = (PIN_GAP_NS / 50);
  localparam int PIN_GAP_CYCLES = (PIN_GAP_CYCLES_RAW < 1) ? 1 : PIN_GAP_CYCLES_RAW;
  localparam int GAP_WIDTH = 9;
  // cc level codes from the comparator, in millivolts
  localparam int LEVEL_WIDTH = 12;
  localparam logic [11:0] MV_200 = 12'h0c8;
  localparam logic [11:0] MV_400 = 12'h190;
  localparam logic [11:0] MV_800 = 12'h320;
  localparam logic [11:0] MV_1600 = 12'h640;
  localparam logic [11:0] MV_2600 = 12'ha28;
  // advertised current
  typedef enum logic [1:0] {ADV_DEFAULT = 2'h0, ADV_1A5 = 2'h1, ADV_3A = 2'h2} pgs_adv_type;
  // classified cc line state
  typedef enum logic [1:0] {
    CC_OPEN = 2'h0,
    CC_POWERED_CABLE = 2'h1,
    CC_SINK_PULLDOWN = 2'h2
  } pgs_cc_type;
  // requested source rail
  typedef enum logic [1:0] {RAIL_5V = 2'h0, RAIL_9V = 2'h1, RAIL_20V = 2'h2} pgs_rail_type;
  // sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    ST_UNATTACHED = 3'h0,
    ST_SINK_CURRENT_PROFILE_SELECT = 3'h1,
    ST_SINK_ON = 3'h3,
    ST_SRC_ON = 3'h2,
    ST_SRC_SWAP = 3'h6
  } pgs_state_type;
endpackage

// ===== hw/pgs_cc_classifier.sv
// classifies the digitised cc line level by advertised current
`timescale 1ns/1ps
module pgs_cc_classifier (
  input wire logic [pgs_pkg::LEVEL_WIDTH-1:0] i_level_mv,
  input wire pgs_pkg::pgs_adv_type i_advert,
  output pgs_pkg::pgs_cc_type o_cc_state
);
  logic [pgs_pkg::LEVEL_WIDTH-1:0] cable_limit;
  logic [pgs_pkg::LEVEL_WIDTH-1:0] sink_limit;

  always_comb
  begin
    case (i_advert)
      pgs_pkg::ADV_1A5:
      begin
        cable_limit = pgs_pkg::MV_400; // see R11
        sink_limit = pgs_pkg::MV_1600;
      end
      pgs_pkg::ADV_3A:
      begin
        cable_limit = pgs_pkg::MV_800; // see R12
        sink_limit = pgs_pkg::MV_2600;
      end
      default:
      begin
        cable_limit = pgs_pkg::MV_200; // see R10
        sink_limit = pgs_pkg::MV_1600;
      end
    endcase
    if (i_level_mv < cable_limit)
      o_cc_state = pgs_pkg::CC_POWERED_CABLE;
    else if (i_level_mv < sink_limit)
      o_cc_state = pgs_pkg::CC_SINK_PULLDOWN;
    else
      o_cc_state = pgs_pkg::CC_OPEN;
  end
endmodule

// ===== hw/pgs_sequencer.sv
// power gpio sequencer: sink load sequencing, source rail pins, cc attach
`timescale 1ns/1ps
// Functional notes
// R1: sinking: raise matching current-select pin first, then load enable.
// R2: current-select to load-enable gap stays within 12.5 us.
// R3: sourcing starts at 5 V; higher rail only if allowed.
// R4: 5 V rail has its own enable; each higher rail its own select.
// R5: enable high at all rails; 9 V or 20 V select only at that rail.
// R6: stepping up from 5 V just raises that rail's select.
// R7: between higher rails old select falls, new rises within 12.5 us.
// R8: both ends start unattached before cable power.
// R9: source attaches only after sink pull-down; then VBUS and VCONN on.
// R10: default advert: below 0.20 V cable, below 1.60 V sink, else open.
// R11: 1.5 A advert: below 0.40 V cable, below 1.60 V sink, else open.
// R12: 3 A advert: below 0.80 V cable, below 2.60 V sink, else open.
// R13: detach or reset drives all pins low and returns to unattached.
module pgs_sequencer #(
  parameter int PROFILES = 4,
  parameter int GAP_CYCLES = pgs_pkg::PIN_GAP_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_sink_mode,
  input wire logic i_source_mode,
  input wire logic i_contract_valid,
  input wire logic [$clog2(PROFILES)-1:0] i_profile,
  input wire pgs_pkg::pgs_rail_type i_rail_request,
  input wire logic i_rail_allowed,
  input wire logic i_vbus_present,
  input wire logic [pgs_pkg::LEVEL_WIDTH-1:0] i_cc_level_mv,
  input wire pgs_pkg::pgs_adv_type i_advert,
  output logic [PROFILES-1:0] o_current_profile_select,
  output logic o_load_enable,
  output logic o_supply_enable,
  output logic o_rail_9v_select,
  output logic o_rail_20v_select,
  output logic o_vbus_on,
  output logic o_vconn_on,
  output logic o_attached,
  output pgs_pkg::pgs_cc_type o_cc_state
);
  typedef struct packed {
    logic [1:0] sink_meta;
    logic [1:0] sink_sync;
    logic [1:0] src_meta;
    logic [1:0] src_sync;
    logic vbus_meta;
    logic vbus_sync;
    pgs_pkg::pgs_state_type state;
    logic [pgs_pkg::GAP_WIDTH-1:0] gap;
    pgs_pkg::pgs_rail_type rail;
    pgs_pkg::pgs_rail_type target;
    logic [PROFILES-1:0] current_profile_select;
    logic load_en;
    logic supply_en;
    logic sel_9v;
    logic sel_20v;
    logic vbus_on;
    logic vconn_on;
    logic attached;
    pgs_pkg::pgs_cc_type cc;
  } pgs_state_reg_type;

  pgs_state_reg_type state_reg;
  pgs_state_reg_type state_next;
  pgs_pkg::pgs_cc_type cc_now;

  localparam logic [pgs_pkg::GAP_WIDTH-1:0] GAP_LAST = pgs_pkg::GAP_WIDTH'(GAP_CYCLES - 1);
  localparam logic [pgs_pkg::GAP_WIDTH-1:0] GAP_ZERO = '0;

  // cc level arrives from an analog comparator block on this clock
  pgs_cc_classifier u_classifier (
    .i_level_mv(i_cc_level_mv),
    .i_advert(i_advert),
    .o_cc_state(cc_now)
  );

  function automatic logic [PROFILES-1:0] one_hot(input logic [$clog2(PROFILES)-1:0] idx);
    logic [PROFILES-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  always_comb
  begin
    state_next = state_reg;
    state_next.sink_meta = {i_source_mode, i_sink_mode};
    state_next.sink_sync = state_reg.sink_meta;
    state_next.src_meta = {i_rail_allowed, i_contract_valid};
    state_next.src_sync = state_reg.src_meta;
    state_next.vbus_meta = i_vbus_present;
    state_next.vbus_sync = state_reg.vbus_meta;
    state_next.cc = cc_now;
    case (state_reg.state)
      pgs_pkg::ST_UNATTACHED:
      begin
        state_next.gap = GAP_ZERO;
        if (state_reg.sink_sync[0] && state_reg.src_sync[0] && state_reg.vbus_sync)
        begin
          state_next.current_profile_select = one_hot(i_profile); // see R1
          state_next.attached = 1'b1;
          state_next.state = pgs_pkg::ST_SINK_CURRENT_PROFILE_SELECT;
        end
        else if (state_reg.sink_sync[1] && state_reg.cc == pgs_pkg::CC_SINK_PULLDOWN)
        begin
          // attach only once the sink pull-down is seen; start at 5 V
          state_next.attached = 1'b1; // see R9
          state_next.vbus_on = 1'b1;
          state_next.vconn_on = 1'b1;
          state_next.supply_en = 1'b1; // see R3
          state_next.rail = pgs_pkg::RAIL_5V;
          state_next.state = pgs_pkg::ST_SRC_ON;
        end
      end
      pgs_pkg::ST_SINK_CURRENT_PROFILE_SELECT:
      begin
        // enable follows select inside the allowed gap
        if (state_reg.gap == GAP_LAST)
        begin
          state_next.load_en = 1'b1; // see R2
          state_next.state = pgs_pkg::ST_SINK_ON;
        end
        else
          state_next.gap = state_reg.gap + 1'b1;
      end
      pgs_pkg::ST_SINK_ON:
      begin
        // a new profile while loaded: select moves, enable stays
        if (state_reg.src_sync[0])
          state_next.current_profile_select = one_hot(i_profile);
      end
      pgs_pkg::ST_SRC_ON:
      begin
        state_next.gap = GAP_ZERO;
        if (state_reg.src_sync[1] && i_rail_request != state_reg.rail)
        begin
          if (i_rail_request == pgs_pkg::RAIL_5V || state_reg.rail == pgs_pkg::RAIL_5V)
          begin
            // step to or from 5 V touches only one select
            state_next.sel_9v = (i_rail_request == pgs_pkg::RAIL_9V); // see R5
            state_next.sel_20v = (i_rail_request == pgs_pkg::RAIL_20V); // see R6
            state_next.rail = i_rail_request;
          end
          else
          begin
            // old select drops first so two rails never overlap
            state_next.sel_9v = 1'b0; // see R7
            state_next.sel_20v = 1'b0;
            state_next.target = i_rail_request;
            state_next.state = pgs_pkg::ST_SRC_SWAP;
          end
        end
      end
      pgs_pkg::ST_SRC_SWAP:
      begin
        if (state_reg.gap == GAP_LAST)
        begin
          state_next.sel_9v = (state_reg.target == pgs_pkg::RAIL_9V); // see R4
          state_next.sel_20v = (state_reg.target == pgs_pkg::RAIL_20V); // see R7
          state_next.rail = state_reg.target;
          state_next.state = pgs_pkg::ST_SRC_ON;
        end
        else
          state_next.gap = state_reg.gap + 1'b1;
      end
      default:
        state_next.state = pgs_pkg::ST_UNATTACHED;
    endcase
    // detach: sink loses vbus or its role, source loses the sink pull-down or its role
    if ((state_reg.state == pgs_pkg::ST_SINK_CURRENT_PROFILE_SELECT || state_reg.state == pgs_pkg::ST_SINK_ON)
        && !(state_reg.vbus_sync && state_reg.sink_sync[0]))
      state_next.state = pgs_pkg::ST_UNATTACHED;
    if ((state_reg.state == pgs_pkg::ST_SRC_ON || state_reg.state == pgs_pkg::ST_SRC_SWAP)
        && (state_reg.cc != pgs_pkg::CC_SINK_PULLDOWN || !state_reg.sink_sync[1]))
      state_next.state = pgs_pkg::ST_UNATTACHED;
    if (state_next.state == pgs_pkg::ST_UNATTACHED)
    begin
      state_next.current_profile_select = '0; // see R13
      state_next.load_en = 1'b0;
      state_next.supply_en = 1'b0;
      state_next.sel_9v = 1'b0;
      state_next.sel_20v = 1'b0;
      state_next.vbus_on = 1'b0;
      state_next.vconn_on = 1'b0;
      state_next.attached = 1'b0;
      state_next.rail = pgs_pkg::RAIL_5V;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= '0; // see R8
      state_reg.state <= pgs_pkg::ST_UNATTACHED;
      state_reg.cc <= pgs_pkg::CC_OPEN;
    end
    else
      state_reg <= state_next;
  end

  assign o_current_profile_select = state_reg.current_profile_select;
  assign o_load_enable = state_reg.load_en;
  assign o_supply_enable = state_reg.supply_en;
  assign o_rail_9v_select = state_reg.sel_9v;
  assign o_rail_20v_select = state_reg.sel_20v;
  assign o_vbus_on = state_reg.vbus_on;
  assign o_vconn_on = state_reg.vconn_on;
  assign o_attached = state_reg.attached;
  assign o_cc_state = state_reg.cc;
endmodule

// ===== sim/pgs_cc_partner.sv
// sink termination on the cc line seen by the source
`timescale 1ns/1ps
module pgs_cc_partner (
  input wire logic [11:0] i_rd_mv,
  output logic [11:0] o_cc_mv
);
  // no termination: pull-up lifts the line, so start unattached
  assign o_cc_mv = (i_rd_mv == 12'h000) ? 12'hbb8 : i_rd_mv;
endmodule

// ===== sim/pgs_sequencer_asserts.sv
// assertions on the sequencer pins
`timescale 1ns/1ps
module pgs_sequencer_asserts #(
  parameter int PROFILES = 4,
  parameter int GAP_CYCLES = pgs_pkg::PIN_GAP_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire pgs_pkg::pgs_rail_type i_rail_request,
  input wire logic [PROFILES-1:0] o_current_profile_select,
  input wire logic o_load_enable,
  input wire logic o_supply_enable,
  input wire logic o_rail_9v_select,
  input wire logic o_rail_20v_select,
  input wire logic o_vbus_on,
  input wire logic o_vconn_on,
  input wire logic o_attached,
  input wire pgs_pkg::pgs_cc_type o_cc_state
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  wire logic sel = |o_current_profile_select;
  wire logic hi = o_rail_9v_select | o_rail_20v_select;
  AST_CURRENT_PROFILE_SELECT_FIRST: assert property ($rose(o_load_enable) |-> sel)
    else $error("load without select");
  AST_LOAD_GAP: assert property ($rose(sel) |-> ##[1:GAP_CYCLES] (o_load_enable | !sel))
    else $error("load late");
  AST_RAIL_CODE: assert property (hi |->
    o_supply_enable & !(o_rail_9v_select & o_rail_20v_select))
    else $error("bad rail code");
  AST_START_5V: assert property ($rose(o_supply_enable) |-> !hi)
    else $error("supply not at 5v");
  AST_STEP_9V: assert property ($rose(o_rail_9v_select) |->
    $past(o_supply_enable) && i_rail_request == pgs_pkg::RAIL_9V)
    else $error("bad 9v step");
  AST_SWAP_GAP: assert property ($fell(o_rail_9v_select) && o_supply_enable &&
    i_rail_request == pgs_pkg::RAIL_20V |-> ##[1:GAP_CYCLES] o_rail_20v_select)
    else $error("20v late");
  AST_ATTACH_SINK: assert property ($rose(o_vbus_on) |->
    $past(o_cc_state) == pgs_pkg::CC_SINK_PULLDOWN)
    else $error("vbus without sink");
  AST_VCONN: assert property (o_vbus_on |-> o_vconn_on & o_attached)
    else $error("vconn off");
  AST_DETACH_LOW: assert property (!o_attached |->
    !(sel | o_load_enable | o_supply_enable | hi | o_vbus_on))
    else $error("pin high detached");
endmodule
bind pgs_sequencer pgs_sequencer_asserts #(.PROFILES(PROFILES), .GAP_CYCLES(GAP_CYCLES)) u_chk (.*);

// ===== sim/tb_top.sv
// bench for the power gpio sequencer
`timescale 1ns/1ps
module tb_top;
  localparam int GAP = 4;
  logic i_clock = 1'b0, i_resetn = 1'b0, i_sink_mode = 1'b0, i_source_mode = 1'b0;
  logic i_contract_valid = 1'b0, i_rail_allowed = 1'b0, i_vbus_present = 1'b0;
  logic [1:0] i_profile = 2'h0;
  logic [11:0] i_cc_level_mv, rd_mv = 12'h000;
  pgs_pkg::pgs_rail_type i_rail_request = pgs_pkg::RAIL_5V;
  pgs_pkg::pgs_adv_type i_advert = pgs_pkg::ADV_DEFAULT;
  logic [3:0] o_current_profile_select;
  logic o_load_enable, o_supply_enable, o_rail_9v_select, o_rail_20v_select;
  logic o_vbus_on, o_vconn_on, o_attached;
  pgs_pkg::pgs_cc_type o_cc_state;
  int fails = 0, n_compared = 0, n;
  wire logic [10:0] outs = {o_current_profile_select, o_load_enable, o_supply_enable,
    o_rail_9v_select, o_rail_20v_select, o_vbus_on, o_vconn_on, o_attached};
  // {advert, class, level}
  logic [15:0] cc_tab [9] = '{16'h1064, 16'h212c, 16'h06a4, 16'h512c, 16'h61f4,
    16'h46a4, 16'h92bc, 16'ha7d0, 16'h8bb8};
  always #25 i_clock = ~i_clock;
  pgs_sequencer #(.GAP_CYCLES(GAP)) u_pgs_sequencer (.*);
  pgs_cc_partner u_pgs_cc_partner (.i_rd_mv(rd_mv), .o_cc_mv(i_cc_level_mv));
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(negedge i_clock);
  endtask
  task hung(input int k);
    if (k >= 40)
    begin
      fails++;
      end_of_test;
    end
  endtask
  task t_sink;
    i_profile = 2'h2;
    {i_sink_mode, i_contract_valid, i_vbus_present} = 3'h7;
    for (n = 0; n < 40 && o_attached !== 1'b1; n++) tick(1);
    hung(n);
    chk(outs, 11'h201, "select first");
    for (n = 0; n < 40 && o_load_enable !== 1'b1; n++) tick(1);
    hung(n);
    chk(n, GAP, "load gap");
    chk(outs, 11'h241, "loaded");
    i_profile = 2'h3;
    tick(1);
    chk(outs, 11'h441, "profile moves");
    i_vbus_present = 1'b0;
    for (n = 0; n < 40 && o_attached !== 1'b0; n++) tick(1);
    hung(n);
    chk(outs, 11'h000, "sink detach");
    {i_sink_mode, i_contract_valid} = 2'h0;
    $display("sink done");
  endtask
  task t_reset;
    i_profile = 2'h1;
    {i_sink_mode, i_contract_valid, i_vbus_present} = 3'h7;
    for (n = 0; n < 40 && o_attached !== 1'b1; n++) tick(1);
    hung(n);
    chk(outs, 11'h101, "second profile");
    i_resetn = 1'b0;
    tick(1);
    chk(outs, 11'h000, "reset pins low");
    {i_sink_mode, i_contract_valid, i_vbus_present} = 3'h0;
    tick(2);
    i_resetn = 1'b1;
    tick(2);
    chk(outs, 11'h000, "unattached after reset");
    $display("reset done");
  endtask
  task t_cc;
    foreach (cc_tab[k])
    begin
      i_advert = pgs_pkg::pgs_adv_type'(cc_tab[k][15:14]);
      rd_mv = cc_tab[k][11:0];
      tick(2);
      chk(o_cc_state, cc_tab[k][13:12], "cc class");
    end
    rd_mv = 12'h000;
    i_advert = pgs_pkg::ADV_DEFAULT;
    $display("cc done");
  endtask
  task t_source;
    i_source_mode = 1'b1;
    tick(8);
    chk(o_attached, 1'b0, "open attach");
    rd_mv = 12'h3e8;
    for (n = 0; n < 40 && o_vbus_on !== 1'b1; n++) tick(1);
    hung(n);
    chk(outs, 11'h027, "5v start");
    i_rail_request = pgs_pkg::RAIL_9V;
    tick(8);
    chk(outs, 11'h027, "9v refused");
    i_rail_allowed = 1'b1;
    tick(8);
    chk(outs, 11'h037, "9v pins");
    i_rail_request = pgs_pkg::RAIL_20V;
    tick(1);
    chk(outs, 11'h027, "9v dropped first");
    for (n = 0; n < 40 && o_rail_20v_select !== 1'b1; n++) tick(1);
    hung(n);
    chk(n, GAP, "swap gap");
    chk(outs, 11'h02f, "20v pins");
    i_rail_request = pgs_pkg::RAIL_5V;
    tick(8);
    chk(outs, 11'h027, "back 5v");
    i_rail_request = pgs_pkg::RAIL_20V;
    tick(8);
    chk(outs, 11'h02f, "20v step");
    rd_mv = 12'h000;
    for (n = 0; n < 40 && o_attached !== 1'b0; n++) tick(1);
    hung(n);
    chk(outs, 11'h000, "source detach");
    $display("source done");
  endtask
  initial
  begin
    tick(16);
    i_resetn = 1'b1;
    chk(outs, 11'h000, "reset pins");
    t_sink;
    t_reset;
    t_cc;
    t_source;
    end_of_test;
  end
endmodule
